// [verilog/exseq_top.sv]
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "exseq_defines.svh"

// Functional notes
// - Four ordered steps per exception
// - Snapshot status word before any change
// - Set supervisor bit after snapshot
// - Clear both trace control bits
// - Reset and interrupt also update mask
// - Interrupt vector from acknowledge read cycle
// - Coprocessor supplies vector in its primitive
// - Other exceptions use internal vector numbers
// - Frame size by type and stage
// - Interrupt with M set: marker frame
// - Reset clears M, skips frame
// - M set: tasks master, interrupts interrupt stack
// - Vector address is base plus number times four
// - Read new PC, fetch instruction, resume
// - Interrupt, bus error, reset are external sources
// - Trap style instructions raise exceptions
// - Trace acts as high priority interrupt
// - Illegal, odd fetch, privilege raise exceptions
// - Privilege primitive faults when supervisor clear
// - Coprocessor exception acknowledged then processed
// - Interrupts serviced while coprocessor busy
module exseq_top
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [2:0] irq_level_pin,
  input wire logic bus_error_pin,
  input wire logic reset_req_pin,
  input wire logic trace_pending,
  input wire logic illegal_op,
  input wire logic odd_fetch,
  input wire logic priv_fault,
  input wire logic instr_exc,
  input wire logic [2:0] instr_kind,
  input wire logic [3:0] trap_num,
  input wire logic [31:0] ret_pc,
  input wire logic [31:0] fault_addr,
  input wire logic cp_resp_valid,
  input wire logic [2:0] cp_prim,
  input wire logic [7:0] cp_vec,
  output logic cp_ack,
  output logic cp_query_hold,
  output logic mem_req,
  output logic mem_we,
  output logic mem_iack,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic resume,
  output logic [31:0] new_pc,
  output logic [31:0] first_insn,
  output logic [1:0] exc_step
);

  exseq_pkg::exseq_state_t state;
  exseq_pkg::exseq_src_t src, src_q;
  logic [4:0] pin_s1, pin_s2, pin_s3, pin_clean, pin_prev;
  logic [7:0] pend, pend_set, pend_clr, vec_int, vec_q, cp_vec_q, vec_clr;
  logic [2:0] cp_prim_q, lvl_q, irq_lvl;
  logic [3:0] fw, fmt, fw_q, fmt_q, cnt;
  logic [15:0] sr, sr_snap;
  logic [31:0] vector_base_register, master_stack_pointer, interrupt_stack_pointer, wdata_q, wr_val, wr_cur, push_sp;
  logic [31:0] next_addr, next_wdata;
  logic [7:0] awaddr_q;
  logic [3:0] wstrb_q;
  logic aw_held, w_held, do_wr, wr_ok, sw_ok;
  logic irq_ok, take, is_irq, is_reset, use_msp, m_was, mem_op, mem_step, next_we;

  // Register read view, shared by reads and write merging
  function automatic logic [31:0] reg_rd(input logic [7:0] a);
    case (a)
      `EXSEQ_OFF_SR: reg_rd = {16'h0000, sr};
      `EXSEQ_OFF_VBR: reg_rd = vector_base_register;
      `EXSEQ_OFF_MSP: reg_rd = master_stack_pointer;
      `EXSEQ_OFF_ISP: reg_rd = interrupt_stack_pointer;
      `EXSEQ_OFF_STAT: reg_rd = {state != exseq_pkg::ST_IDLE, 15'h0, cnt, src_q, vec_q};
      `EXSEQ_OFF_NEWPC: reg_rd = new_pc;
      default: reg_rd = 32'h00000000;
    endcase
  endfunction

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a[1:0] == 2'h0) && (a <= `EXSEQ_OFF_NEWPC);
  endfunction

  // Pins: three stages; a change counts once the last two agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1 <= 5'h00;
      pin_s2 <= 5'h00;
      pin_s3 <= 5'h00;
      pin_clean <= 5'h00;
      pin_prev <= 5'h00;
    end
    else
    begin
      pin_s1 <= {irq_level_pin, bus_error_pin, reset_req_pin};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_clean <= (pin_s3 & ~(pin_s2 ^ pin_s3)) | (pin_clean & (pin_s2 ^ pin_s3));
      pin_prev <= pin_clean;
    end
  end

  assign irq_lvl = pin_clean[4:2];
  // Level seven cannot be masked
  assign irq_ok = (irq_lvl > sr[`EXSEQ_SR_MASK_HI:`EXSEQ_SR_MASK_LO]) ||
    (irq_lvl == `EXSEQ_MASK_MAX);

  // Event capture; reset and bus error pins by edge, so a held pin is taken once; other events set pending each cycle they are high
  always_comb
  begin
    pend_set = 8'h00;
    pend_set[`EXSEQ_PB_RESET] = pin_clean[0] && !pin_prev[0];
    pend_set[`EXSEQ_PB_BUSERR] = pin_clean[1] && !pin_prev[1];
    pend_set[`EXSEQ_PB_ADDR] = odd_fetch;
    pend_set[`EXSEQ_PB_CP] = cp_resp_valid && (cp_prim == `EXSEQ_PRIM_PRE ||
      cp_prim == `EXSEQ_PRIM_MID || cp_prim == `EXSEQ_PRIM_POST);
    pend_set[`EXSEQ_PB_INSTR] = instr_exc;
    pend_set[`EXSEQ_PB_ILL] = illegal_op;
    pend_set[`EXSEQ_PB_PRIV] = priv_fault || (cp_resp_valid &&
      cp_prim == `EXSEQ_PRIM_PRIV && !sr[`EXSEQ_SR_S]);
    pend_set[`EXSEQ_PB_TRACE] = trace_pending;
  end

  // Set wins over the clear of the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pend <= 8'h00;
    else
      pend <= (pend & ~pend_clr) | pend_set;
  end

  // Coprocessor vector and stage kept until the exception is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cp_vec_q <= 8'h00;
      cp_prim_q <= 3'h0;
    end
    else if (pend_set[`EXSEQ_PB_CP])
    begin
      cp_vec_q <= cp_vec;
      cp_prim_q <= cp_prim;
    end
  end

  exseq_vector u_vector
  (
    .pend(pend),
    .irq_ok(irq_ok),
    .instr_kind(instr_kind),
    .trap_num(trap_num),
    .cp_vec(cp_vec_q),
    .cp_prim(cp_prim_q),
    .src(src),
    .vec(vec_int),
    .fw(fw),
    .fmt(fmt),
    .clr(vec_clr)
  );

  // Interrupts are taken in idle even mid coprocessor wait
  assign take = (state == exseq_pkg::ST_IDLE) && (src != exseq_pkg::SRC_NONE);
  assign pend_clr = take ? vec_clr : 8'h00;
  assign is_irq = (src_q == exseq_pkg::SRC_IRQ);
  assign is_reset = (src_q == exseq_pkg::SRC_RESET);
  assign cp_query_hold = (state != exseq_pkg::ST_IDLE);
  assign mem_step = mem_req && mem_ack;

  // Sequencer proper
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= exseq_pkg::ST_IDLE;
      src_q <= exseq_pkg::SRC_NONE;
      vec_q <= 8'h00;
      fw_q <= 4'h0;
      fmt_q <= 4'h0;
      cnt <= 4'h0;
      lvl_q <= 3'h0;
      use_msp <= 1'b0;
      m_was <= 1'b0;
      sr_snap <= 16'h0000;
      new_pc <= 32'h00000000;
      first_insn <= 32'h00000000;
      resume <= 1'b0;
      cp_ack <= 1'b0;
    end
    else
    begin
      resume <= 1'b0;
      cp_ack <= 1'b0;
      unique case (state)
        exseq_pkg::ST_IDLE:
          if (take)
          begin
            src_q <= src;
            vec_q <= vec_int;
            fw_q <= fw;
            fmt_q <= fmt;
            lvl_q <= irq_lvl;
            cp_ack <= (src == exseq_pkg::SRC_CP);
            state <= exseq_pkg::ST_SNAP;
          end
        exseq_pkg::ST_SNAP:
        begin
          sr_snap <= sr;
          use_msp <= sr[`EXSEQ_SR_M] && !is_irq;
          m_was <= sr[`EXSEQ_SR_M] && is_irq;
          cnt <= fw_q - 4'h1;
          // Reset goes straight to its vector
          state <= is_reset ? exseq_pkg::ST_FETCH : exseq_pkg::ST_VECT;
        end
        exseq_pkg::ST_VECT:
          if (!is_irq)
            state <= exseq_pkg::ST_PUSH;
          else if (mem_step)
          begin
            vec_q <= mem_rdata[7:0];
            state <= exseq_pkg::ST_PUSH;
          end
        exseq_pkg::ST_PUSH:
          if (mem_step)
          begin
            if (cnt != 4'h0)
              cnt <= cnt - 4'h1;
            else if (m_was)
            begin
              cnt <= `EXSEQ_FW_MARK - 4'h1;
              state <= exseq_pkg::ST_MARK;
            end
            else
              state <= exseq_pkg::ST_FETCH;
          end
        exseq_pkg::ST_MARK:
          if (mem_step)
          begin
            if (cnt != 4'h0)
              cnt <= cnt - 4'h1;
            else
              state <= exseq_pkg::ST_FETCH;
          end
        exseq_pkg::ST_FETCH:
          if (mem_step)
          begin
            new_pc <= mem_rdata;
            state <= exseq_pkg::ST_INSN;
          end
        exseq_pkg::ST_INSN:
          if (mem_step)
          begin
            first_insn <= mem_rdata;
            resume <= 1'b1;
            state <= exseq_pkg::ST_IDLE;
          end
        default: state <= exseq_pkg::ST_IDLE; // Three-bit code has an unused value
      endcase
    end
  end

  // Step shown to the pipeline: 0 status, 1 vector, 2 stack, 3 fetch
  always_comb
  begin
    unique case (state)
      exseq_pkg::ST_VECT: exc_step = 2'h1;
      exseq_pkg::ST_PUSH, exseq_pkg::ST_MARK: exc_step = 2'h2;
      exseq_pkg::ST_FETCH, exseq_pkg::ST_INSN: exc_step = 2'h3;
      default: exc_step = 2'h0;
    endcase
  end

  // Address, data and direction of the bus cycle each state needs
  assign push_sp = (state == exseq_pkg::ST_MARK || use_msp) ? master_stack_pointer : interrupt_stack_pointer;
  always_comb
  begin
    mem_op = 1'b1;
    next_we = 1'b0;
    next_addr = push_sp - 32'h00000004;
    next_wdata = 32'h00000000;
    unique case (state)
      exseq_pkg::ST_VECT:
      begin
        mem_op = is_irq;
        next_addr = {29'h0, lvl_q};
      end
      exseq_pkg::ST_PUSH, exseq_pkg::ST_MARK:
      begin
        next_we = 1'b1;
        // Word 0 lands lowest: format, vector offset, saved status
        if (cnt == 4'h0)
          next_wdata = {(state == exseq_pkg::ST_MARK) ? `EXSEQ_FMT_MARK : fmt_q, 2'h0,
            vec_q, 2'h0, sr_snap};
        else if (cnt == 4'h1)
          next_wdata = ret_pc;
        else
          next_wdata = fault_addr;
      end
      exseq_pkg::ST_FETCH: next_addr = vector_base_register + {22'h0, vec_q, 2'h0};
      exseq_pkg::ST_INSN: next_addr = new_pc;
      default: mem_op = 1'b0;
    endcase
  end

  // One outstanding cycle; request held until acknowledged
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_iack <= 1'b0;
      mem_addr <= 32'h00000000;
      mem_wdata <= 32'h00000000;
    end
    else if (mem_step)
    begin
      mem_req <= 1'b0;
      mem_iack <= 1'b0;
    end
    else if (mem_op && !mem_req)
    begin
      mem_req <= 1'b1;
      mem_we <= next_we;
      mem_iack <= (state == exseq_pkg::ST_VECT);
      mem_addr <= next_addr;
      mem_wdata <= next_wdata;
    end
  end

  // Software may only change state while no exception is in flight
  assign do_wr = aw_held && w_held && !bvalid;
  assign sw_ok = (state == exseq_pkg::ST_IDLE);
  assign wr_ok = do_wr && sw_ok;
  // Strobed bytes merge into the current value; a process so register changes are seen
  always_comb
  begin
    wr_cur = reg_rd(awaddr_q);
    wr_val = {wstrb_q[3] ? wdata_q[31:24] : wr_cur[31:24],
      wstrb_q[2] ? wdata_q[23:16] : wr_cur[23:16],
      wstrb_q[1] ? wdata_q[15:8] : wr_cur[15:8],
      wstrb_q[0] ? wdata_q[7:0] : wr_cur[7:0]};
  end

  // Status word: entry changes take priority over software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sr <= `EXSEQ_SR_RST;
    else if (state == exseq_pkg::ST_SNAP)
    begin
      sr[`EXSEQ_SR_S] <= 1'b1;
      sr[`EXSEQ_SR_T1] <= 1'b0;
      sr[`EXSEQ_SR_T0] <= 1'b0;
      if (is_irq)
      begin
        sr[`EXSEQ_SR_MASK_HI:`EXSEQ_SR_MASK_LO] <= lvl_q;
        sr[`EXSEQ_SR_M] <= 1'b0;
      end
      else if (is_reset)
      begin
        sr[`EXSEQ_SR_MASK_HI:`EXSEQ_SR_MASK_LO] <= `EXSEQ_MASK_MAX;
        sr[`EXSEQ_SR_M] <= 1'b0;
      end
    end
    else if (wr_ok && awaddr_q == `EXSEQ_OFF_SR)
      sr <= wr_val[15:0];
  end

  // Stack pointers and vector base
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      vector_base_register <= 32'h00000000;
      master_stack_pointer <= 32'h00000000;
      interrupt_stack_pointer <= 32'h00000000;
    end
    else if (mem_step && (state == exseq_pkg::ST_PUSH || state == exseq_pkg::ST_MARK))
    begin
      if (state == exseq_pkg::ST_MARK || use_msp)
        master_stack_pointer <= master_stack_pointer - 32'h00000004;
      else
        interrupt_stack_pointer <= interrupt_stack_pointer - 32'h00000004;
    end
    else if (wr_ok)
    begin
      if (awaddr_q == `EXSEQ_OFF_VBR)
        vector_base_register <= wr_val;
      if (awaddr_q == `EXSEQ_OFF_MSP)
        master_stack_pointer <= wr_val;
      if (awaddr_q == `EXSEQ_OFF_ISP)
        interrupt_stack_pointer <= wr_val;
    end
  end

  // Bus slave: address and data taken in either order
  assign awready = !aw_held;
  assign wready = !w_held;
  assign arready = !rvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `EXSEQ_RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_held <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_held <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (do_wr)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= reg_hit(awaddr_q) ? `EXSEQ_RESP_OKAY : `EXSEQ_RESP_DECERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `EXSEQ_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata <= reg_rd(araddr);
      rresp <= reg_hit(araddr) ? `EXSEQ_RESP_OKAY : `EXSEQ_RESP_DECERR;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_step_order: assert property ((state == exseq_pkg::ST_SNAP && !is_reset) |=>
    state == exseq_pkg::ST_VECT) else $error("step two did not follow step one");
  a_snap_value: assert property (state == exseq_pkg::ST_SNAP |=>
    sr_snap == $past(sr)) else $error("snapshot differs from old status");
  a_super_set: assert property (state == exseq_pkg::ST_SNAP |=>
    sr[`EXSEQ_SR_S]) else $error("supervisor bit not set on entry");
  a_trace_off: assert property (state == exseq_pkg::ST_SNAP |=>
    !sr[`EXSEQ_SR_T1] && !sr[`EXSEQ_SR_T0]) else $error("trace bits survive entry");
  a_mask_load: assert property ((state == exseq_pkg::ST_SNAP && is_irq) |=>
    sr[`EXSEQ_SR_MASK_HI:`EXSEQ_SR_MASK_LO] == lvl_q) else $error("mask not raised");
  a_iack_read: assert property (mem_iack |->
    mem_req && !mem_we && state == exseq_pkg::ST_VECT) else $error("bad acknowledge cycle");
  a_reset_skip: assert property ((state == exseq_pkg::ST_SNAP && is_reset) |=>
    !sr[`EXSEQ_SR_M] && state == exseq_pkg::ST_FETCH) else $error("reset built a frame");
  a_vec_addr: assert property ((state == exseq_pkg::ST_FETCH && mem_req) |->
    mem_addr == vector_base_register + {22'h0, vec_q, 2'h0}) else $error("wrong vector address");
  a_marker_msp: assert property ((state == exseq_pkg::ST_MARK && mem_req) |->
    mem_we && mem_addr == master_stack_pointer - 32'h00000004) else $error("marker not on master stack");
  a_irq_isp: assert property ((state == exseq_pkg::ST_PUSH && is_irq && mem_req) |->
    mem_addr == interrupt_stack_pointer - 32'h00000004) else $error("interrupt frame not on interrupt stack");
  a_cp_ack: assert property ((take && src == exseq_pkg::SRC_CP) |=>
    cp_ack ##1 !cp_ack ##0 state != exseq_pkg::ST_IDLE) else $error("coprocessor not acked");
  a_resume_pc: assert property ((state == exseq_pkg::ST_INSN && mem_step) |=>
    resume && first_insn == $past(mem_rdata)) else $error("no resume after fetch");

  c_irq_marker: cover property (state == exseq_pkg::ST_MARK ##[1:200] resume);
  c_reset_run: cover property (is_reset && state == exseq_pkg::ST_FETCH ##[1:100] resume);
  c_cp_take: cover property (cp_ack ##[1:300] resume);
  c_cp_priv: cover property (cp_resp_valid && cp_prim == `EXSEQ_PRIM_PRIV && !sr[`EXSEQ_SR_S]);

endmodule

// [inc/exseq_defines.svh]
`ifndef EXSEQ_DEFINES_SVH
`define EXSEQ_DEFINES_SVH

// Status word layout and reset value
`define EXSEQ_SR_RST 16'h2700
`define EXSEQ_SR_T1 15
`define EXSEQ_SR_T0 14
`define EXSEQ_SR_S 13
`define EXSEQ_SR_M 12
`define EXSEQ_SR_MASK_HI 10
`define EXSEQ_SR_MASK_LO 8
`define EXSEQ_MASK_MAX 3'h7

// Register byte offsets and bus response codes
`define EXSEQ_OFF_SR 8'h00
`define EXSEQ_OFF_VBR 8'h04
`define EXSEQ_OFF_MSP 8'h08
`define EXSEQ_OFF_ISP 8'h0C
`define EXSEQ_OFF_STAT 8'h10
`define EXSEQ_OFF_NEWPC 8'h14
`define EXSEQ_RESP_OKAY 2'h0
`define EXSEQ_RESP_DECERR 2'h3

// Pending event bit positions
`define EXSEQ_PB_RESET 0
`define EXSEQ_PB_BUSERR 1
`define EXSEQ_PB_ADDR 2
`define EXSEQ_PB_CP 3
`define EXSEQ_PB_INSTR 4
`define EXSEQ_PB_ILL 5
`define EXSEQ_PB_PRIV 6
`define EXSEQ_PB_TRACE 7

// Internally generated vector numbers
`define EXSEQ_VEC_RESET 8'h00
`define EXSEQ_VEC_BUSERR 8'h02
`define EXSEQ_VEC_ADDR 8'h03
`define EXSEQ_VEC_ILL 8'h04
`define EXSEQ_VEC_DIV 8'h05
`define EXSEQ_VEC_BOUNDS 8'h06
`define EXSEQ_VEC_CONDITIONAL_TRAP_INSTRUCTION 8'h07
`define EXSEQ_VEC_PRIV 8'h08
`define EXSEQ_VEC_TRACE 8'h09
`define EXSEQ_VEC_TRAP 8'h20

// Instruction trap kinds
`define EXSEQ_KIND_TRAP 3'h0
`define EXSEQ_KIND_CONDITIONAL_TRAP_INSTRUCTION 3'h1
`define EXSEQ_KIND_OVERFLOW_TRAP_INSTRUCTION 3'h2
`define EXSEQ_KIND_COPROCESSOR_CONDITIONAL_TRAP 3'h3
`define EXSEQ_KIND_BOUNDS 3'h4
`define EXSEQ_KIND_DIV 3'h5

// Coprocessor primitive codes
`define EXSEQ_PRIM_PRIV 3'h1
`define EXSEQ_PRIM_PRE 3'h2
`define EXSEQ_PRIM_MID 3'h3
`define EXSEQ_PRIM_POST 3'h4

// Frame sizes in words and frame format codes
`define EXSEQ_FW_SHORT 4'h4
`define EXSEQ_FW_POST 4'h6
`define EXSEQ_FW_MID 4'hA
`define EXSEQ_FW_MARK 4'h4
`define EXSEQ_FMT_SHORT 4'h0
`define EXSEQ_FMT_MARK 4'h1
`define EXSEQ_FMT_POST 4'h2
`define EXSEQ_FMT_MID 4'h9

`endif

// [inc/exseq_pkg.sv]
package exseq_pkg;

  typedef enum logic [2:0] {ST_IDLE, ST_SNAP, ST_VECT, ST_PUSH, ST_MARK, ST_FETCH,
    ST_INSN} exseq_state_t;

  typedef enum logic [3:0] {SRC_NONE, SRC_RESET, SRC_BUSERR, SRC_ADDR, SRC_CP, SRC_INSTR,
    SRC_ILL, SRC_PRIV, SRC_TRACE, SRC_IRQ} exseq_src_t;

endpackage

// [verilog/exseq_vector.sv]
`timescale 1ns/10ps
`include "exseq_defines.svh"

module exseq_vector
(
  input wire logic [7:0] pend,
  input wire logic irq_ok,
  input wire logic [2:0] instr_kind,
  input wire logic [3:0] trap_num,
  input wire logic [7:0] cp_vec,
  input wire logic [2:0] cp_prim,
  output exseq_pkg::exseq_src_t src,
  output logic [7:0] vec,
  output logic [3:0] fw,
  output logic [3:0] fmt,
  output logic [7:0] clr
);

  // Fixed priority, reset first, interrupts last
  always_comb
  begin
    src = exseq_pkg::SRC_NONE;
    vec = `EXSEQ_VEC_RESET;
    fw = `EXSEQ_FW_SHORT;
    fmt = `EXSEQ_FMT_SHORT;
    clr = 8'h00;
    if (pend[`EXSEQ_PB_RESET])
    begin
      src = exseq_pkg::SRC_RESET;
      clr[`EXSEQ_PB_RESET] = 1'b1;
    end
    else if (pend[`EXSEQ_PB_BUSERR])
    begin
      src = exseq_pkg::SRC_BUSERR;
      vec = `EXSEQ_VEC_BUSERR;
      fw = `EXSEQ_FW_MID;
      fmt = `EXSEQ_FMT_MID;
      clr[`EXSEQ_PB_BUSERR] = 1'b1;
    end
    else if (pend[`EXSEQ_PB_ADDR])
    begin
      src = exseq_pkg::SRC_ADDR;
      vec = `EXSEQ_VEC_ADDR;
      fw = `EXSEQ_FW_MID;
      fmt = `EXSEQ_FMT_MID;
      clr[`EXSEQ_PB_ADDR] = 1'b1;
    end
    else if (pend[`EXSEQ_PB_CP])
    begin
      src = exseq_pkg::SRC_CP;
      vec = cp_vec;
      clr[`EXSEQ_PB_CP] = 1'b1;
      // Frame depth follows where the coprocessor stopped
      if (cp_prim == `EXSEQ_PRIM_MID)
      begin
        fw = `EXSEQ_FW_MID;
        fmt = `EXSEQ_FMT_MID;
      end
      else if (cp_prim == `EXSEQ_PRIM_POST)
      begin
        fw = `EXSEQ_FW_POST;
        fmt = `EXSEQ_FMT_POST;
      end
    end
    else if (pend[`EXSEQ_PB_INSTR])
    begin
      src = exseq_pkg::SRC_INSTR;
      clr[`EXSEQ_PB_INSTR] = 1'b1;
      fw = `EXSEQ_FW_POST;
      fmt = `EXSEQ_FMT_POST;
      case (instr_kind)
        `EXSEQ_KIND_TRAP:
        begin
          vec = `EXSEQ_VEC_TRAP | {4'h0, trap_num};
          fw = `EXSEQ_FW_SHORT;
          fmt = `EXSEQ_FMT_SHORT;
        end
        `EXSEQ_KIND_BOUNDS: vec = `EXSEQ_VEC_BOUNDS;
        `EXSEQ_KIND_DIV: vec = `EXSEQ_VEC_DIV;
        default: vec = `EXSEQ_VEC_CONDITIONAL_TRAP_INSTRUCTION; // Conditional, overflow, coprocessor traps
      endcase
    end
    else if (pend[`EXSEQ_PB_ILL])
    begin
      src = exseq_pkg::SRC_ILL;
      vec = `EXSEQ_VEC_ILL;
      clr[`EXSEQ_PB_ILL] = 1'b1;
    end
    else if (pend[`EXSEQ_PB_PRIV])
    begin
      src = exseq_pkg::SRC_PRIV;
      vec = `EXSEQ_VEC_PRIV;
      clr[`EXSEQ_PB_PRIV] = 1'b1;
    end
    else if (pend[`EXSEQ_PB_TRACE])
    begin
      src = exseq_pkg::SRC_TRACE;
      vec = `EXSEQ_VEC_TRACE;
      fw = `EXSEQ_FW_POST;
      fmt = `EXSEQ_FMT_POST;
      clr[`EXSEQ_PB_TRACE] = 1'b1;
    end
    else if (irq_ok)
    begin
      src = exseq_pkg::SRC_IRQ;
    end
  end

endmodule

// [tb/exseq_mem.sv]
`timescale 1ns/10ps
module exseq_mem
#(
  parameter int DLY = 2
)
(
  input wire logic aclk,
  input wire logic mem_req,
  input wire logic mem_iack,
  input wire logic [31:0] mem_addr,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  int cnt = 0;
  // Slow memory; data only valid in the ack cycle, else scrambled
  always @(posedge aclk)
  begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack)
    begin
      cnt <= cnt + 1;
      if (cnt == DLY)
      begin
        cnt <= 0;
        mem_ack <= 1'b1;
        mem_rdata <= mem_iack ? 32'h00000040 : mem_addr + 32'h00000100;
      end
    end
  end
endmodule

// [tb/testbench.sv]
`timescale 1ns/10ps
module testbench;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0, cp_vec = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rd, mem_rdata;
  logic [1:0] bresp, rresp, rs;
  logic awready, wready, bvalid, arready, rvalid, mem_ack, resume, mem_req, mem_iack;
  logic [31:0] rdata, mem_addr, new_pc, first_insn, mem_wdata, last_wd;
  logic [2:0] irq = 0, kind = 0, prim = 0;
  logic [3:0] tnum = 0, strb = 4'hF;
  logic ill = 0, iexc = 0, cpv = 0, odd = 0, rst_req = 0;
  logic mem_we, cp_ack, cp_query_hold;
  logic [1:0] exc_step;
  int error_cnt = 0, checked = 0, wcnt = 0, acks = 0;
  always #25 aclk = ~aclk;
  exseq_mem u_exseq_mem (.aclk(aclk), .mem_req(mem_req), .mem_iack(mem_iack),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  exseq_top u_exseq_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(strb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .irq_level_pin(irq), .bus_error_pin(1'b0), .reset_req_pin(rst_req), .trace_pending(1'b0),
    .illegal_op(ill), .odd_fetch(odd), .priv_fault(1'b0), .instr_exc(iexc),
    .instr_kind(kind), .trap_num(tnum), .ret_pc(32'h00000A00), .fault_addr(32'h00000B00),
    .cp_resp_valid(cpv), .cp_prim(prim), .cp_vec(cp_vec), .cp_ack(cp_ack),
    .cp_query_hold(cp_query_hold), .mem_req(mem_req), .mem_we(mem_we), .mem_iack(mem_iack),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .resume(resume), .new_pc(new_pc), .first_insn(first_insn), .exc_step(exc_step));
  // Far-side tally of frame writes and acks, taken mid-cycle to stay clear of the edge
  always @(negedge aclk)
  begin
    if (mem_req && mem_ack && mem_we)
    begin
      wcnt++;
      last_wd = mem_wdata;
    end
    if (cp_ack)
      acks++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Write: both channels offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (int n = 0; n < 100 && !tb; n++)
    begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      @(posedge aclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      if (tb) bready <= 0;
    end
    if (!tb) error_cnt++;
    if (!tb) close_out();
  endtask
  task automatic rdr(input logic [7:0] a);
    logic ta, tr;
    tr = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (int n = 0; n < 100 && !tr; n++)
    begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 0;
      if (tr) rready <= 0;
    end
    if (!tr) error_cnt++;
    if (!tr) close_out();
  endtask
  // Resume is a one-cycle pulse, so it is looked at every cycle
  task automatic wait_res(input logic [31:0] pc, input int words);
    logic seen;
    logic [2:0] st;
    int base;
    seen = 0;
    st = 0;
    base = wcnt;
    for (int n = 0; n < 400 && !seen; n++)
    begin
      @(negedge aclk);
      seen = resume;
      st = st | {cp_query_hold, exc_step};
    end
    if (!seen) error_cnt++;
    if (!seen) close_out();
    chk(new_pc, pc);
    chk(first_insn, pc + 32'h00000100);
    chk(st, 32'h00000007);
    chk(wcnt - base, words);
    @(posedge aclk);
  endtask
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rdr(8'h00);
    chk(rd, 32'h00002700);
    wr(8'h04, 32'h00001000);
    wr(8'h0C, 32'h00008000);
    wr(8'h08, 32'h00009000);
    wr(8'h00, 32'h0000E300);
    ill <= 1;
    @(posedge aclk);
    ill <= 0;
    wait_res(32'h00001110, 4);
    chk(last_wd, 32'h0010E300);
    rdr(8'h00);
    chk(rd, 32'h00002300);
    rdr(8'h0C);
    chk(rd, 32'h00007FF0);
    // Only byte one strobed; the low byte keeps its old value
    strb <= 4'h2;
    wr(8'h00, 32'h000030FF);
    strb <= 4'hF;
    irq <= 3'h5;
    wait_res(32'h00001200, 8);
    chk(last_wd, 32'h11003000);
    irq <= 3'h0;
    rdr(8'h00);
    chk(rd, 32'h00002500);
    rdr(8'h0C);
    chk(rd, 32'h00007FE0);
    rdr(8'h08);
    chk(rd, 32'h00008FF0);
    iexc <= 1;
    tnum <= 4'h3;
    @(posedge aclk);
    iexc <= 0;
    wait_res(32'h0000118C, 4);
    cpv <= 1;
    prim <= 3'h2;
    cp_vec <= 8'h30;
    @(posedge aclk);
    cpv <= 0;
    wait_res(32'h000011C0, 4);
    chk(acks, 1);
    chk(last_wd, 32'h00C02500);
    odd <= 1;
    @(posedge aclk);
    odd <= 0;
    wait_res(32'h0000110C, 10);
    rdr(8'h0C);
    chk(rd, 32'h00007F98);
    // Reset request: mask to seven, no frame, stack pointers untouched
    rst_req <= 1;
    wait_res(32'h00001100, 0);
    rst_req <= 0;
    rdr(8'h00);
    chk(rd, 32'h00002700);
    rdr(8'h0C);
    chk(rd, 32'h00007F98);
    rdr(8'h18);
    chk({30'h0, rs}, 32'h00000003);
    close_out();
  end
endmodule
